// file: hdl/hbdv_band.sv
/*
 High-band dynamic volume: high-pass stage, exponential-average level, four-
 segment curve and slewed gain, configured over APB.
 Assumes one sample_in_valid pulse per fs and a zero-wait APB master.
*/
`timescale 1ns/1ps
// Overview of operation
// R1: band input runs through first-order high-pass A(1-z^-1)/(1+Bz^-1).
// R2: filter enable 0 outputs zero data; 1 runs the filter.
// R3: software changes coefficients only while some enable is off.
// R4: filter starts within four sample periods after enables are set.
// R5: coefficients are two's complement with 13 fractional bits.
// R6: software keeps cut-off at or above fs/10000.
// R7: points one and two map code n to -1.5n dB, up to 2Fh.
// R8: point three uses 5-bit codes, -1.5n dB, defaults zero.
// R9: software keeps X and Y points non-decreasing.
// R10: four 7-bit slopes are rise over run times 16, default zero.
// R11: fourth point X is full scale, Y follows from fourth slope.
// R12: gain starts from a value set by the first slope.
// R13: software writes points and slopes only while an enable is off.
// R14: gain control starts within four samples after enables set.
// R15: gain attenuates or recovers so level meets the curve.
// R16: averaging field picks 256, 512, 1024 or 2048 samples.
// R17: attenuation speed codes 0 to 6 double, 7 unavailable.
// R18: recovery speed codes 0 to 6 double, 7 unavailable.
// R19: software changes averaging and speeds only while an enable is off.
// R20: gain steps once per sample, so speed scales with fs.
module hbdv_band #(
    parameter int W = 24
)(
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [hbdv_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [hbdv_pkg::DATA_W-1:0]  pwdata,
    output logic      [hbdv_pkg::DATA_W-1:0]  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         sample_in_valid,
    input  wire logic signed [W-1:0]          sample_in,
    output logic                              sample_out_valid,
    output logic signed [W-1:0]               sample_out
);
    import hbdv_pkg::*;

    typedef struct packed {
        hbdv_state_e                fsm;
        logic [2:0]                 warm;
        logic                       filt_en;
        logic                       dac_en;
        logic                       rce_en;
        logic [1:0]                 avg_sel;
        logic [2:0]                 att_sel;
        logic [2:0]                 rec_sel;
        logic [COEF_W-1:0]          ca;
        logic [COEF_W-1:0]          cb;
        logic [PT_W-1:0]            p1x;
        logic [PT_W-1:0]            p1y;
        logic [PT_W-1:0]            p2x;
        logic [PT_W-1:0]            p2y;
        logic [PT3_W-1:0]           p3x;
        logic [PT3_W-1:0]           p3y;
        logic [SLOPE_W-1:0]         s1;
        logic [SLOPE_W-1:0]         s2;
        logic [SLOPE_W-1:0]         s3;
        logic [SLOPE_W-1:0]         s4;
        logic [AVG_W-1:0]           avg;
        logic signed [GAIN_W-1:0]   gain;
        logic signed [W-1:0]        out;
        logic                       out_v;
        logic [DATA_W-1:0]          rdata;
        logic                       rdy;
        logic                       err;
    } hbdv_top_s;

    hbdv_top_s                  st;
    hbdv_top_s                  next_st;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return (a == REG_CTRL) || (a == REG_COEF) || (a == REG_PTS12) ||
               (a == REG_PT3) || (a == REG_SLOPE) || (a == REG_STATUS);
    endfunction

    // unavailable codes behave as the highest legal code
    function automatic int pt_units(input logic [PT_W-1:0] c);
        return int'((c > PT_MAX) ? PT_MAX : c) * UNIT_PER_CODE;
    endfunction

    function automatic logic [2:0] spd_code(input logic [2:0] c);
        return (c > SPEED_MAX) ? SPEED_MAX : c;
    endfunction

    function automatic int seg(input int att, input int x0, input int y0, input logic [SLOPE_W-1:0] s);
        return y0 + ((int'(s) * (att - x0)) >>> SLOPE_SH);
    endfunction

    function automatic int clampg(input int g);
        return (g < GAIN_MIN) ? GAIN_MIN : ((g > GAIN_MAX) ? GAIN_MAX : g);
    endfunction

    // coarse log: 64 units per octave, six mantissa bits interpolated
    function automatic int lvl_att(input logic [LVL_MSB:0] lvl);
        int                 p;
        logic [LVL_MSB:0]   sh;
        p = -1;
        for (int i = 0; i <= LVL_MSB; i++) begin
            if (lvl[i])
                p = i;
        end
        sh = lvl << (LVL_MSB - p);
        if (p < 0)
            return ATT_FLOOR;
        return (LVL_MSB - p) * UNIT_PER_OCT - int'(sh[LVL_MSB-1:MANT_LSB]);
    endfunction

    // 2^(-k/8) in Q15
    function automatic logic [15:0] frac_gain(input logic [2:0] k);
        unique case (k)
            3'h0: return 16'h8000;
            3'h1: return 16'h7560;
            3'h2: return 16'h6ba2;
            3'h3: return 16'h62b4;
            3'h4: return 16'h5a82;
            3'h5: return 16'h52ff;
            3'h6: return 16'h4c1c;
            3'h7: return 16'h45cb;
        endcase
    endfunction

    function automatic logic signed [W-1:0] sat(input logic signed [DATA_W-1:0] v);
        if (v > $signed(DATA_W'({1'b0, {(W-1){1'b1}}})))
            return {1'b0, {(W-1){1'b1}}};
        if (v < -$signed(DATA_W'({1'b1, {(W-1){1'b0}}})))
            return {1'b1, {(W-1){1'b0}}};
        return v[W-1:0];
    endfunction

    logic                       run;
    logic                       en_all;
    logic                       setup;
    logic                       access;
    int                         x1u;
    int                         y1u;
    int                         x2u;
    int                         y2u;
    int                         x3u;
    int                         y3u;
    int                         att_in;
    int                         c_out;
    int                         g_int;
    int                         e;
    logic signed [GAIN_W-1:0]   tgt_q;
    logic signed [GAIN_W-1:0]   init_q;
    logic signed [GAIN_W-1:0]   att_step;
    logic signed [GAIN_W-1:0]   rec_step;
    logic signed [GAIN_W-1:0]   gain_up;
    logic signed [GAIN_W-1:0]   gain_dn;
    logic signed [GAIN_W-1:0]   next_gain;
    logic [21:0]                lin;
    logic signed [46:0]         prod;
    logic [W-1:0]               mag;
    logic signed [AVG_W+1:0]    avg_diff;
    logic [AVG_W-1:0]           next_avg;

    hbdv_stream_if #(.W(W)) hp_in ();
    hbdv_stream_if #(.W(W)) hp_out ();

    assign run = (st.fsm == HBDV_RUN);
    assign en_all = st.dac_en & st.rce_en;
    assign setup = psel & ~penable;
    assign access = psel & penable & st.rdy;

    // R4: filter fed only once running
    assign hp_in.valid = sample_in_valid & run;
    assign hp_in.data = sample_in;

    hbdv_hpf #(.W(W), .CW(COEF_W)) u_hpf (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clear   (~run | ~st.filt_en),
        .coef_a  ($signed(st.ca)),
        .coef_b  ($signed(st.cb)),
        .s_in    (hp_in),
        .s_out   (hp_out)
    );

    // R7: curve points in units
    assign x1u = pt_units(st.p1x);
    assign y1u = pt_units(st.p1y);
    assign x2u = pt_units(st.p2x);
    assign y2u = pt_units(st.p2y);
    // R8: 5-bit third point
    assign x3u = int'(st.p3x) * UNIT_PER_CODE;
    assign y3u = int'(st.p3y) * UNIT_PER_CODE;
    assign att_in = lvl_att(st.avg[AVG_FRAC+LVL_MSB:AVG_FRAC]);

    // R10: slope per segment; R11: fourth runs to full scale
    assign c_out = (att_in <= x1u) ? seg(att_in, 0, 0, st.s1) :
                   (att_in <= x2u) ? seg(att_in, x1u, y1u, st.s2) :
                   (att_in <= x3u) ? seg(att_in, x2u, y2u, st.s3) :
                   seg(att_in, x3u, y3u, st.s4);
    assign tgt_q = GAIN_W'(clampg(c_out - att_in) <<< GAIN_FRAC);
    // R12: start gain from first slope
    assign init_q = GAIN_W'(clampg(((int'(st.s1) - SLOPE_UNITY) * x1u) >>> SLOPE_SH) <<< GAIN_FRAC);

    // R17: attenuation step doubles per code
    assign att_step = GAIN_W'(ATT_STEP_BASE << spd_code(st.att_sel));
    // R18: recovery step doubles per code
    assign rec_step = GAIN_W'(REC_STEP_BASE << spd_code(st.rec_sel));
    assign gain_up = st.gain + att_step;
    assign gain_dn = st.gain - rec_step;
    // R15: slew toward the curve, never past it
    assign next_gain = (st.gain < tgt_q) ? ((gain_up > tgt_q) ? tgt_q : gain_up) :
                       ((gain_dn < tgt_q) ? tgt_q : gain_dn);

    assign g_int = clampg(int'(st.gain >>> GAIN_FRAC));
    assign e = g_int - GAIN_MIN;
    assign lin = 22'({frac_gain(e[5:3]), 6'h0} >> (e >>> BOOST_SH));
    assign prod = hp_out.data * $signed({1'b0, lin});

    // R16: exponential average over 256..2048 samples
    assign mag = hp_out.data[W-1] ? W'(-hp_out.data) : W'(hp_out.data);
    assign avg_diff = $signed({2'h0, mag, AVG_FRAC'(0)}) - $signed({2'h0, st.avg});
    assign next_avg = AVG_W'($signed({2'h0, st.avg}) + (avg_diff >>> (AVG_SH_BASE + int'(st.avg_sel))));

    always_comb begin
        next_st = st;
        next_st.out_v = 1'b0;
        next_st.rdy = 1'b0;
        if (setup) begin
            next_st.rdy = 1'b1;
            next_st.err = ~reg_hit(paddr);
            next_st.rdata = '0;
            unique case (paddr)
                REG_CTRL: next_st.rdata = DATA_W'({st.rec_sel, st.att_sel, st.avg_sel,
                                                   st.rce_en, st.dac_en, st.filt_en});
                REG_COEF: next_st.rdata = DATA_W'({st.cb, 2'h0, st.ca});
                REG_PTS12: next_st.rdata = DATA_W'({st.p2y, st.p2x, st.p1y, st.p1x});
                REG_PT3: next_st.rdata = DATA_W'({st.p3y, st.p3x});
                REG_SLOPE: next_st.rdata = DATA_W'({st.s4, st.s3, st.s2, st.s1});
                REG_STATUS: next_st.rdata = {16'(g_int), 14'h0, st.filt_en & run, run};
                default: next_st.rdata = '0;
            endcase
        end else if (access && pwrite) begin
            unique case (paddr)
                REG_CTRL: begin
                    next_st.filt_en = pwdata[CTRL_FILT];
                    next_st.dac_en = pwdata[CTRL_DAC];
                    next_st.rce_en = pwdata[CTRL_RCE];
                    next_st.avg_sel = pwdata[CTRL_AVG+:2];
                    next_st.att_sel = pwdata[CTRL_ATT+:3];
                    next_st.rec_sel = pwdata[CTRL_REC+:3];
                end
                REG_COEF: begin
                    next_st.ca = pwdata[COEF_W-1:0];
                    next_st.cb = pwdata[COEF_B_LSB+:COEF_W];
                end
                REG_PTS12: {next_st.p2y, next_st.p2x, next_st.p1y, next_st.p1x} = pwdata[4*PT_W-1:0];
                REG_PT3: {next_st.p3y, next_st.p3x} = pwdata[2*PT3_W-1:0];
                REG_SLOPE: {next_st.s4, next_st.s3, next_st.s2, next_st.s1} = pwdata[4*SLOPE_W-1:0];
                default: ;
            endcase
        end
        unique case (st.fsm)
            HBDV_IDLE: begin
                if (en_all) begin
                    next_st.fsm = HBDV_WARM;
                    next_st.warm = '0;
                end
            end
            // R14: two-sample warm-up keeps start inside four
            HBDV_WARM: begin
                if (!en_all)
                    next_st.fsm = HBDV_IDLE;
                else if (sample_in_valid) begin
                    if (st.warm == WARM_LAST) begin
                        next_st.fsm = HBDV_RUN;
                        next_st.gain = init_q;
                        next_st.avg = '0;
                    end else
                        next_st.warm = st.warm + 3'h1;
                end
            end
            HBDV_RUN: begin
                if (!en_all)
                    next_st.fsm = HBDV_IDLE;
                // R20: one gain step per sample
                else if (hp_out.valid) begin
                    next_st.out_v = 1'b1;
                    // R2: disabled band emits zero
                    next_st.out = st.filt_en ? sat(DATA_W'(prod >>> LIN_FRAC)) : '0;
                    next_st.avg = next_avg;
                    next_st.gain = next_gain;
                end
            end
            default: next_st.fsm = HBDV_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.fsm <= HBDV_IDLE;
            st.avg_sel <= AVG_RST;
            st.att_sel <= ATT_RST;
            st.rec_sel <= REC_RST;
        end else
            st <= next_st;
    end

    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.err;
    assign sample_out_valid = st.out_v;
    assign sample_out = st.out;

    // samples seen since both enables went high, for the start check
    logic [2:0] samp_cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            samp_cnt <= '0;
        else if (!en_all)
            samp_cnt <= '0;
        else if (sample_in_valid && samp_cnt != START_MAX_SAMPLES)
            samp_cnt <= samp_cnt + 3'h1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_off_zero;
        sample_out_valid |-> ($past(st.filt_en) || sample_out == '0);
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("disabled band output not zero"); // R2

    property p_start_max;
        (en_all && samp_cnt == START_MAX_SAMPLES) |-> run;
    endproperty
    a_start_max: assert property (p_start_max) else $error("band not running after four samples"); // R4

    property p_stop;
        !en_all |=> st.fsm == HBDV_IDLE ##1 !sample_out_valid;
    endproperty
    a_stop: assert property (p_stop) else $error("band kept running while disabled"); // R14

    property p_init_gain;
        $rose(run) |-> st.gain == $past(init_q);
    endproperty
    a_init_gain: assert property (p_init_gain) else $error("start gain not from first slope"); // R12

    property p_att_step;
        (run && en_all && hp_out.valid && gain_up <= tgt_q && st.gain < tgt_q)
            |=> st.gain == $past(st.gain) + $past(att_step);
    endproperty
    a_att_step: assert property (p_att_step) else $error("attenuation step wrong"); // R17

    property p_rec_step;
        (run && en_all && hp_out.valid && gain_dn >= tgt_q && st.gain >= tgt_q)
            |=> st.gain == $past(st.gain) - $past(rec_step);
    endproperty
    a_rec_step: assert property (p_rec_step) else $error("recovery step wrong"); // R18

    property p_gain_hold;
        (run && !hp_out.valid) |=> $stable(st.gain);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain moved between samples"); // R20

    property p_out_lat;
        (run && en_all && sample_in_valid) ##1 (run && en_all) |=> sample_out_valid;
    endproperty
    a_out_lat: assert property (p_out_lat) else $error("filtered sample missing"); // R1

    property p_toward_curve;
        (run && en_all && hp_out.valid && st.gain != tgt_q) |=>
            (($past(st.gain) < $past(tgt_q)) == (st.gain > $past(st.gain)));
    endproperty
    a_toward_curve: assert property (p_toward_curve) else $error("gain moved away from curve"); // R15

    c_run: cover property ($rose(run));
    c_att: cover property (run && hp_out.valid && st.gain < tgt_q);
    c_rec: cover property (run && hp_out.valid && st.gain > tgt_q);
    c_off: cover property (sample_out_valid && !st.filt_en);
endmodule

// file: hdl/hbdv_hpf.sv
/*
 First-order high-pass stage y = A(x - x1) - B*y1, Q13 coefficients.
 Assumes coefficients stay still while running; clear empties history.
*/
`timescale 1ns/1ps
module hbdv_hpf #(
    parameter int W  = 24,
    parameter int CW = 14
)(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 clear,
    input  wire logic signed [CW-1:0] coef_a,
    input  wire logic signed [CW-1:0] coef_b,
    hbdv_stream_if.snk                s_in,
    hbdv_stream_if.src                s_out
);
    import hbdv_pkg::*;

    typedef struct packed {
        logic signed [W-1:0] x1;
        logic signed [W-1:0] y1;
        logic                v;
    } hbdv_hpf_s;

    hbdv_hpf_s               st;
    hbdv_hpf_s               next_st;
    logic signed [W:0]       diff;
    logic signed [CW+W:0]    pa;
    logic signed [CW+W-1:0]  pb;
    logic signed [CW+W+1:0]  acc;
    logic signed [CW+W+1:0]  shr;

    // R1: difference and feedback
    assign diff = {s_in.data[W-1], s_in.data} - {st.x1[W-1], st.x1};
    assign pa = coef_a * diff;
    assign pb = coef_b * st.y1;
    assign acc = {pa[CW+W], pa} - {{2{pb[CW+W-1]}}, pb};
    // R5: drop 13 fractional bits
    assign shr = acc >>> COEF_FRAC;

    always_comb begin
        next_st = st;
        next_st.v = s_in.valid;
        if (clear) begin
            next_st.x1 = '0;
            next_st.y1 = '0;
        end else if (s_in.valid) begin
            next_st.x1 = s_in.data;
            // saturate rather than wrap: a wrap would be a full-scale click
            if (shr > $signed({{(CW+2){1'b0}}, {1'b0, {(W-1){1'b1}}}}))
                next_st.y1 = {1'b0, {(W-1){1'b1}}};
            else if (shr < -$signed({{(CW+2){1'b0}}, {1'b1, {(W-1){1'b0}}}}))
                next_st.y1 = {1'b1, {(W-1){1'b0}}};
            else
                next_st.y1 = shr[W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign s_out.valid = st.v;
    assign s_out.data = st.y1;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_clear_hist;
        clear |=> (st.x1 == '0) && (s_out.data == '0);
    endproperty
    a_clear_hist: assert property (p_clear_hist) else $error("history not cleared"); // R1
endmodule

// file: hdl/hbdv_pkg.sv
/*
 Shared constants for the high-band dynamic volume block: register map,
 field positions, reset values, gain arithmetic scaling and state codes.
 Assumes a 32-bit APB register bus and one sample strobe per fs.
*/
package hbdv_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SAMPLE_W = 24;
    localparam int COEF_W = 14;
    localparam int COEF_FRAC = 13;

    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_COEF   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_PTS12  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_PT3    = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_SLOPE  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;

    localparam int CTRL_FILT = 0;
    localparam int CTRL_DAC = 1;
    localparam int CTRL_RCE = 2;
    localparam int CTRL_AVG = 3;
    localparam int CTRL_ATT = 5;
    localparam int CTRL_REC = 8;
    localparam int COEF_B_LSB = 16;
    localparam int PT_W = 6;
    localparam int PT3_W = 5;
    localparam int SLOPE_W = 7;
    localparam int STAT_GAIN_LSB = 16;

    localparam logic [1:0] AVG_RST = 2'h3;
    localparam logic [2:0] ATT_RST = 3'h3;
    localparam logic [2:0] REC_RST = 3'h3;
    localparam logic [PT_W-1:0] PT_MAX = 6'h2f;
    localparam logic [2:0] SPEED_MAX = 3'h6;

    // level and gain are kept in units of 1.5 dB / 16
    localparam int UNIT_PER_CODE = 16;
    localparam int UNIT_PER_OCT = 64;
    localparam int SLOPE_SH = 4;
    localparam int SLOPE_UNITY = 16;
    localparam int LVL_MSB = 23;
    localparam int MANT_LSB = 17;
    localparam int ATT_FLOOR = 1536;
    localparam int AVG_FRAC = 11;
    localparam int AVG_W = 35;
    localparam int AVG_SH_BASE = 8;
    localparam int GAIN_W = 28;
    localparam int GAIN_FRAC = 16;
    localparam int GAIN_MIN = -384;
    localparam int GAIN_MAX = 1535;
    localparam int BOOST_SH = 6;
    localparam int LIN_FRAC = 15;
    // per-sample steps, 2^-16 unit, at the slowest speed code
    localparam int ATT_STEP_BASE = 93;
    localparam int REC_STEP_BASE = 6;

    localparam logic [2:0] WARM_LAST = 3'h1;
    localparam logic [2:0] START_MAX_SAMPLES = 3'h4;

    typedef enum logic [2:0] {
        HBDV_IDLE = 3'b001,
        HBDV_WARM = 3'b010,
        HBDV_RUN  = 3'b100
    } hbdv_state_e;
endpackage

// file: hdl/hbdv_stream_if.sv
/*
 Sample stream carrier between the band top and its high-pass stage.
 Assumes one valid strobe per sample, no back-pressure.
*/
`timescale 1ns/1ps
interface hbdv_stream_if #(
    parameter int W = 24
);
    logic                valid;
    logic signed [W-1:0] data;
    modport src (output valid, output data);
    modport snk (input valid, input data);
endinterface

// file: tb/hbdv_partner.sv
/*
 Sample source and sink around the band: one pulse every PER cycles.
 Assumes one clock and registered band outputs.
*/
`timescale 1ns/1ps
module hbdv_partner #(
    parameter int PER = 16
)(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [23:0] level,
    input  wire logic        sample_out_valid,
    input  wire logic [23:0] sample_out,
    output logic             sample_in_valid,
    output logic [23:0]      sample_in,
    output int               n_in,
    output int               n_out,
    output int               lat,
    output logic [23:0]      last_out
);
    int cnt;
    int since;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {cnt, since, n_in, n_out, lat} <= '0;
            {sample_in_valid, sample_in, last_out} <= '0;
        end else begin
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
            sample_in_valid <= go && cnt == 0;
            // data off the strobe is not held, so show its inverse
            sample_in <= (go && cnt == 0) ? level : ~level;
            since <= sample_in_valid ? 1 : since + 1;
            if (sample_in_valid)
                n_in <= n_in + 1;
            if (sample_out_valid) begin
                n_out <= n_out + 1;
                last_out <= sample_out;
                lat <= since;
            end
        end
    end
endmodule

// file: tb/high_band_dynamic_volume_tb.sv
/*
 Self-checking bench for the band: APB register checks and sample runs.
 Assumes the zero-wait APB slave and partner pulse spacing of 16 cycles.
*/
`timescale 1ns/1ps
module high_band_dynamic_volume_tb;
    import hbdv_pkg::*;
    logic              clk_sys, rst, psel, penable, pwrite, go, pready, pslverr, e;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, q, v;
    logic              sample_in_valid, sample_out_valid;
    logic signed [23:0] sample_in, sample_out, last_out, level;
    int                n_in, n_out, lat, n_errors, tests_run;
    logic [7:0]        ra [4] = '{REG_COEF, REG_PTS12, REG_PT3, REG_SLOPE};
    logic [31:0]       rm [4] = '{32'h3fff3fff, 32'h00ffffff, 32'h000003ff, 32'h0fffffff};

    hbdv_band i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_in_valid(sample_in_valid), .sample_in(sample_in),
        .sample_out_valid(sample_out_valid), .sample_out(sample_out));
    hbdv_partner i_far (.clk_sys(clk_sys), .rst(rst), .go(go), .level(level),
        .sample_out_valid(sample_out_valid), .sample_out(sample_out),
        .sample_in_valid(sample_in_valid), .sample_in(sample_in), .n_in(n_in),
        .n_out(n_out), .lat(lat), .last_out(last_out));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] ctl(input logic f, input logic on, input int avg,
                                        input int att, input int rec);
        return {21'h0, rec[2:0], att[2:0], avg[1:0], on, on, f};
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task wait_out(input int k);
        int t0;
        t0 = n_out;
        // warm-up needs two strobes before the first one is filtered
        repeat (80 * k) begin
            if (n_out >= t0 + k)
                break;
            @(posedge clk_sys);
        end
        chk(n_out >= t0 + k, 1'b1);
    endtask

    // sample run; enables dropped before any field change
    task run(input logic f, input logic [13:0] a);
        int b;
        v = ctl(f, 1'b1, $urandom_range(3), $urandom_range(6), $urandom_range(6));
        bus(1'b1, REG_CTRL, 32'h0);
        bus(1'b1, REG_COEF, {18'h0, a});
        level <= 24'($urandom_range(24'h0fffff));
        bus(1'b1, REG_CTRL, v);
        go <= 1'b1;
        b = n_in;
        wait_out(1);
        chk(n_in - b <= 4, 1'b1);
        chk(lat, 2);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[1:0], {f, 1'b1});
        // zero first slope starts at 0; one recovery step cannot reach a whole unit
        chk(16'(q[31:16] + 16'h1) <= 16'h1, 1'b1);
        wait_out(3);
        chk(last_out, 32'h0);
        level <= level + 24'h100000;
        wait_out(1);
        if (f)
            chk({last_out[23], last_out != 0}, {a[13], 1'b1});
        else
            chk(last_out, 32'h0);
        go <= 1'b0;
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, go, level} = '0;
        n_errors = 0;
        tests_run = 0;
        rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        v = $urandom(21212);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, ctl(1'b0, 1'b0, 3, 3, 3));
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, ra[i], 32'h0);
            chk(q, 32'h0);
            bus(1'b1, ra[i], 32'hffffffff);
            bus(1'b0, ra[i], 32'h0);
            chk(q, rm[i]);
            chk(e, 1'b0);
            v = $urandom;
            bus(1'b1, ra[i], v);
            bus(1'b0, ra[i], 32'h0);
            chk(q, v & rm[i]);
            // random points and slopes could mute the run
            bus(1'b1, ra[i], 32'h0);
        end
        bus(1'b0, 8'h18, 32'h0);
        chk({e, q[0]}, 2'h2);
        bus(1'b1, REG_STATUS, 32'hffffffff);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[1:0], 2'h0);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, REG_CTRL, ctl(1'b0, 1'b0, i % 4, i, 6 - i));
            bus(1'b0, REG_CTRL, 32'h0);
            chk(q, ctl(1'b0, 1'b0, i % 4, i, 6 - i));
        end
        run(1'b1, 14'h1000);
        run(1'b0, 14'h1000);
        run(1'b1, 14'h3000);
        report_and_stop();
    end

    initial begin
        #500000;
        n_errors++;
        report_and_stop();
    end
endmodule
